// File: core/tcp_timer_compare.sv
// output side of a 16-bit free-running timer: two compare channels,
// forced levels, one-pulse and pwm modes, apb register slave
// assumes pins synchronous to clk and a single-cycle apb master
//
// Summary of operation
// - compare match sets compare flag, enabled pin takes match level.
// - compare pin latches are low during reset.
// - compare match interrupts only with compare irq enable and mask clear.
// - flag clears by status read while set, then low compare access.
// - high compare write inhibits compare until low byte written.
// - software writes high, reads status, writes low; low write re-arms.
// - disabled pin is general I/O; interrupt still possible.
// - flag and pin update while counter holds compare value.
// - force bit copies level to enabled pin, no flag, no interrupt.
// - force bits ignored in one-pulse and pwm modes.
// - one-pulse trigger reloads counter, drives level two, captures FFFDh.
// - one-pulse compare 1 match drives level one, ending pulse.
// - one-pulse never sets flag 1; flag 2 still works.
// - pwm and one-pulse both selected means pwm only.
// - one-pulse channel 2 flags elapsed time, makes no waveform.
// - pwm compare values double buffered, loaded at period end.
// - pwm match 1 drives level one, match 2 level two, pin 1.
// - pwm channel 2 match reloads counter with FFFCh.
// - pwm sets no compare flag, so no compare interrupt.
// - pwm channel 2 match sets capture flag 1, may interrupt.
// - pwm disconnects capture pin 1; capture pin 2 still captures.
// - pwm pulse width is compare difference; equal levels give constant.
// - internal timer clock is clk divided by 2, 4 or 8.
// - compare registers reset to 8000h, hardware never changes them.
// - counter resets and reloads only to FFFCh.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "tcp_map.svh"
module tcp_timer_compare
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // capture and clock pins
   input wire logic trigger_capture_pin_1,
   input wire logic trigger_capture_pin_2,
   input wire logic ext_clock_pin,
   // compare pins
   output logic compare_output_pin_1,
   output logic compare_output_pin_1_oe,
   output logic compare_output_pin_2,
   output logic compare_output_pin_2_oe,
   // interrupt
   input wire logic cpu_irq_mask,
   output logic timer_irq
);

   // ==========================================================
   // registers
   logic [7:0] ctrl1_reg;
   logic [7:0] ctrl2_reg;
   tcp_pkg::tcp_word_t cnt_reg;
   tcp_pkg::tcp_word_t cnt_next;
   tcp_pkg::tcp_word_t cmp1_reg;
   tcp_pkg::tcp_word_t cmp2_reg;
   tcp_pkg::tcp_word_t act1_reg;
   tcp_pkg::tcp_word_t act2_reg;
   tcp_pkg::tcp_word_t cap1_reg;
   tcp_pkg::tcp_word_t cap2_reg;
   logic [1:0] inh_reg;
   logic upd_reg;
   logic [4:0] flag_reg;
   logic [4:0] arm_reg;
   logic pin1_reg;
   logic pin2_reg;
   logic [31:0] rdata_reg;

   // ==========================================================
   // bus decode
   logic setup;
   logic access;
   logic wr;
   logic rd;
   logic hit;
   logic [31:0] rmux;
   logic sel_c1, sel_c2, sel_st;
   logic sel_m1h, sel_m1l, sel_m2h, sel_m2l;
   logic sel_nh, sel_nl, sel_p1h, sel_p1l, sel_p2h, sel_p2l;

   assign sel_c1 = (paddr == `TCP_OFF_CTRL1);
   assign sel_c2 = (paddr == `TCP_OFF_CTRL2);
   assign sel_st = (paddr == `TCP_OFF_STATUS);
   assign sel_m1h = (paddr == `TCP_OFF_CMP1_HI);
   assign sel_m1l = (paddr == `TCP_OFF_CMP1_LO);
   assign sel_m2h = (paddr == `TCP_OFF_CMP2_HI);
   assign sel_m2l = (paddr == `TCP_OFF_CMP2_LO);
   assign sel_nh = (paddr == `TCP_OFF_CNT_HI);
   assign sel_nl = (paddr == `TCP_OFF_CNT_LO);
   assign sel_p1h = (paddr == `TCP_OFF_CAP1_HI);
   assign sel_p1l = (paddr == `TCP_OFF_CAP1_LO);
   assign sel_p2h = (paddr == `TCP_OFF_CAP2_HI);
   assign sel_p2l = (paddr == `TCP_OFF_CAP2_LO);
   assign hit = sel_c1 | sel_c2 | sel_st | sel_m1h | sel_m1l | sel_m2h | sel_m2l
              | sel_nh | sel_nl | sel_p1h | sel_p1l | sel_p2h | sel_p2l;

   // read data is captured in the setup cycle, so the access phase never waits
   assign setup = psel & ~penable;
   assign access = psel & penable;
   assign wr = access & pwrite & hit;
   assign rd = access & ~pwrite & hit;
   assign pready = access;
   assign pslverr = access & ~hit;
   assign prdata = rdata_reg;

   // ==========================================================
   // status image
   logic [7:0] status_img;

   assign status_img = {flag_reg[2], flag_reg[0], flag_reg[4], flag_reg[3],
                        flag_reg[1], 3'h0};

   assign rmux = sel_c1 ? {24'h0, ctrl1_reg} :
                 sel_c2 ? {24'h0, ctrl2_reg} :
                 sel_st ? {24'h0, status_img} :
                 sel_m1h ? {24'h0, cmp1_reg[15:8]} :
                 sel_m1l ? {24'h0, cmp1_reg[7:0]} :
                 sel_m2h ? {24'h0, cmp2_reg[15:8]} :
                 sel_m2l ? {24'h0, cmp2_reg[7:0]} :
                 sel_nh ? {24'h0, cnt_reg[15:8]} :
                 sel_nl ? {24'h0, cnt_reg[7:0]} :
                 sel_p1h ? {24'h0, cap1_reg[15:8]} :
                 sel_p1l ? {24'h0, cap1_reg[7:0]} :
                 sel_p2h ? {24'h0, cap2_reg[15:8]} :
                 sel_p2l ? {24'h0, cap2_reg[7:0]} : 32'h0;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         rdata_reg <= 32'h0;
      else if (setup)
         rdata_reg <= rmux;
   end

   // ==========================================================
   // control fields and modes
   logic pwm_mode;
   logic opm_mode;
   logic lvl1, lvl2;
   logic pin1_en, pin2_en;

   assign pwm_mode = ctrl2_reg[`TCP_C2_PWM];
   assign opm_mode = ctrl2_reg[`TCP_C2_ONE_PULSE] & ~pwm_mode;
   assign lvl1 = ctrl1_reg[`TCP_C1_LEVEL1];
   assign lvl2 = ctrl1_reg[`TCP_C1_LEVEL2];
   assign pin1_en = ctrl2_reg[`TCP_C2_PIN1_EN];
   assign pin2_en = ctrl2_reg[`TCP_C2_PIN2_EN];

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         ctrl1_reg <= `TCP_CTRL_RST;
         ctrl2_reg <= `TCP_CTRL_RST;
      end
      else
      begin
         if (wr & sel_c1)
            ctrl1_reg <= pwdata[7:0];
         if (wr & sel_c2)
            ctrl2_reg <= pwdata[7:0];
      end
   end

   // ==========================================================
   // pin edges and tick
   logic [2:0] edge_pin;
   logic [2:0] edge_rise;
   logic [2:0] edge_evt;
   logic tick;

   assign edge_pin = {ext_clock_pin, trigger_capture_pin_2, trigger_capture_pin_1};
   assign edge_rise = {ctrl2_reg[`TCP_C2_EXT_EDGE], ctrl2_reg[`TCP_C2_EDGE2],
                       ctrl1_reg[`TCP_C1_EDGE1]};

   genvar e;
   generate
      for (e = 0; e < 3; e++)
      begin : g_edge
         tcp_edge_det u_edge
         (
            .clk(clk),
            .rst_b(rst_b),
            .pin(edge_pin[e]),
            .rising_sel(edge_rise[e]),
            .evt(edge_evt[e])
         );
      end
   endgenerate

   tcp_tick_gen u_tick
   (
      .clk(clk),
      .rst_b(rst_b),
      .clk_sel(tcp_pkg::tcp_clk_sel_e'(ctrl2_reg[`TCP_C2_CLK_HI:`TCP_C2_CLK_LO])),
      .ext_evt(edge_evt[2]),
      .tick(tick)
   );

   // ==========================================================
   // compare matches
   tcp_pkg::tcp_word_t use1, use2;
   logic match1, match2;
   logic pulse_trig;
   logic reload;

   // pwm compares the buffered copies, other modes the live registers
   assign use1 = pwm_mode ? act1_reg : cmp1_reg;
   assign use2 = pwm_mode ? act2_reg : cmp2_reg;
   // upd_reg marks the first cycle of a new count, so each match fires once
   assign match1 = upd_reg & (cnt_reg == use1) & ~inh_reg[0];
   assign match2 = upd_reg & (cnt_reg == use2) & ~inh_reg[1];
   assign pulse_trig = opm_mode & edge_evt[0];
   assign reload = pulse_trig | (pwm_mode & match2);

   // ==========================================================
   // counter
   always_comb
   begin
      cnt_next = cnt_reg;
      if (reload)
         cnt_next = `TCP_CNT_RELOAD;
      else if (tick)
         cnt_next = cnt_reg + 16'h0001;
   end

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         cnt_reg <= `TCP_CNT_RELOAD;
         upd_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         upd_reg <= tick | reload;
      end
   end

   // ==========================================================
   // compare registers, inhibit and pwm buffers
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         cmp1_reg <= `TCP_CMP_RST;
         cmp2_reg <= `TCP_CMP_RST;
         act1_reg <= `TCP_CMP_RST;
         act2_reg <= `TCP_CMP_RST;
         inh_reg <= 2'h0;
      end
      else
      begin
         if (wr & sel_m1h)
            cmp1_reg[15:8] <= pwdata[7:0];
         if (wr & sel_m1l)
            cmp1_reg[7:0] <= pwdata[7:0];
         if (wr & sel_m2h)
            cmp2_reg[15:8] <= pwdata[7:0];
         if (wr & sel_m2l)
            cmp2_reg[7:0] <= pwdata[7:0];
         if (wr & sel_m1h)
            inh_reg[0] <= 1'b1;
         else if (wr & sel_m1l)
            inh_reg[0] <= 1'b0;
         if (wr & sel_m2h)
            inh_reg[1] <= 1'b1;
         else if (wr & sel_m2l)
            inh_reg[1] <= 1'b0;
         if (!pwm_mode || match2)
         begin
            act1_reg <= cmp1_reg;
            act2_reg <= cmp2_reg;
         end
      end
   end

   // ==========================================================
   // captures
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         cap1_reg <= 16'h0000;
         cap2_reg <= 16'h0000;
      end
      else
      begin
         if (pulse_trig)
            cap1_reg <= `TCP_CAP_PULSE;
         else if (edge_evt[0] & ~pwm_mode)
            cap1_reg <= cnt_reg;
         if (edge_evt[1])
            cap2_reg <= cnt_reg;
      end
   end

   // ==========================================================
   // flags: 0 cmp1, 1 cmp2, 2 cap1, 3 cap2, 4 overflow
   logic [4:0] flag_set;
   logic [4:0] low_acc;

   assign flag_set[0] = match1 & ~opm_mode & ~pwm_mode;
   assign flag_set[1] = match2 & ~pwm_mode;
   assign flag_set[2] = (edge_evt[0] & ~pwm_mode) | (pwm_mode & match2);
   assign flag_set[3] = edge_evt[1];
   assign flag_set[4] = tick & ~reload & (cnt_reg == 16'hFFFF);
   assign low_acc = {sel_nl, sel_p2l, sel_p1l, sel_m2l, sel_m1l} & {5{access}};

   genvar f;
   generate
      for (f = 0; f < 5; f++)
      begin : g_flag
         logic clr;

         // set wins over the second clear step in the same cycle
         assign clr = low_acc[f] & arm_reg[f];
         always_ff @(posedge clk)
         begin
            if (!rst_b)
            begin
               flag_reg[f] <= 1'b0;
               arm_reg[f] <= 1'b0;
            end
            else
            begin
               flag_reg[f] <= flag_set[f] | (flag_reg[f] & ~clr);
               if (rd & sel_st)
                  arm_reg[f] <= flag_reg[f];
               else if (clr)
                  arm_reg[f] <= 1'b0;
            end
         end
      end
   endgenerate

   // ==========================================================
   // compare pins
   logic force_ok;

   assign force_ok = ~opm_mode & ~pwm_mode;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         pin1_reg <= 1'b0;
         pin2_reg <= 1'b0;
      end
      else
      begin
         if (pwm_mode)
         begin
            // equal levels keep the pin constant
            if (match1)
               pin1_reg <= lvl1;
            else if (match2)
               pin1_reg <= lvl2;
         end
         else if (opm_mode)
         begin
            if (pulse_trig)
               pin1_reg <= lvl2;
            else if (match1)
               pin1_reg <= lvl1;
         end
         else if (pin1_en & (match1 | ctrl1_reg[`TCP_C1_FORCE1]))
            pin1_reg <= lvl1;
         if (force_ok & pin2_en & (match2 | ctrl1_reg[`TCP_C1_FORCE2]))
            pin2_reg <= lvl2;
      end
   end

   // a disabled pin is released to general I/O
   assign compare_output_pin_1 = pin1_reg;
   assign compare_output_pin_1_oe = pin1_en;
   assign compare_output_pin_2 = pin2_reg;
   assign compare_output_pin_2_oe = pin2_en & force_ok;

   // ==========================================================
   // interrupt: flags are sticky, so a masked request stays pending
   logic irq_cmp, irq_cap, irq_ovf;

   assign irq_cmp = ctrl1_reg[`TCP_C1_CMP_IRQ_EN] & (flag_reg[0] | flag_reg[1]);
   assign irq_cap = ctrl1_reg[`TCP_C1_CAP_IRQ_EN] & (flag_reg[2] | flag_reg[3]);
   assign irq_ovf = ctrl1_reg[`TCP_C1_OVF_IRQ_EN] & flag_reg[4];
   assign timer_irq = ~cpu_irq_mask & (irq_cmp | irq_cap | irq_ovf);

endmodule : tcp_timer_compare
`default_nettype wire

// File: core/tcp_map.svh
// register offsets, field positions, reset values and divider counts
// of the compare/pulse/pwm timer; included by the timer, tick generator, assertion and bench files
`ifndef TCP_MAP_SVH
`define TCP_MAP_SVH

// ==========================================================
// apb byte offsets, one aligned word each
`define TCP_OFF_CTRL1 12'h000
`define TCP_OFF_CTRL2 12'h004
`define TCP_OFF_STATUS 12'h008
`define TCP_OFF_CMP1_HI 12'h00C
`define TCP_OFF_CMP1_LO 12'h010
`define TCP_OFF_CMP2_HI 12'h014
`define TCP_OFF_CMP2_LO 12'h018
`define TCP_OFF_CNT_HI 12'h01C
`define TCP_OFF_CNT_LO 12'h020
`define TCP_OFF_CAP1_HI 12'h024
`define TCP_OFF_CAP1_LO 12'h028
`define TCP_OFF_CAP2_HI 12'h02C
`define TCP_OFF_CAP2_LO 12'h030

// ==========================================================
// timer_control_one fields
`define TCP_C1_CAP_IRQ_EN 7
`define TCP_C1_CMP_IRQ_EN 6
`define TCP_C1_OVF_IRQ_EN 5
`define TCP_C1_FORCE2 4
`define TCP_C1_FORCE1 3
`define TCP_C1_LEVEL2 2
`define TCP_C1_EDGE1 1
`define TCP_C1_LEVEL1 0

// ==========================================================
// timer_control_two fields
`define TCP_C2_PIN1_EN 7
`define TCP_C2_PIN2_EN 6
`define TCP_C2_ONE_PULSE 5
`define TCP_C2_PWM 4
`define TCP_C2_CLK_HI 3
`define TCP_C2_CLK_LO 2
`define TCP_C2_EDGE2 1
`define TCP_C2_EXT_EDGE 0

// ==========================================================
// timer_status_reg fields
`define TCP_ST_CAP1 7
`define TCP_ST_CMP1 6
`define TCP_ST_OVF 5
`define TCP_ST_CAP2 4
`define TCP_ST_CMP2 3

// ==========================================================
// reset, reload and one-pulse capture values
`define TCP_CTRL_RST 8'h00
`define TCP_CNT_RELOAD 16'hFFFC
`define TCP_CAP_PULSE 16'hFFFD
`define TCP_CMP_RST 16'h8000

// ==========================================================
// divider terminal counts (divisor minus one)
`define TCP_DIV2_LAST 3'h1
`define TCP_DIV4_LAST 3'h3
`define TCP_DIV8_LAST 3'h7

`endif

// File: core/tcp_pkg.sv
// types shared by the compare/pulse/pwm timer files
// assumes nothing of its surroundings
package tcp_pkg;

   // ==========================================================
   // timer clock source, encoded as the clock select field
   typedef enum logic [1:0] {
      TCP_CLK_DIV2,
      TCP_CLK_DIV4,
      TCP_CLK_DIV8,
      TCP_CLK_EXT
   } tcp_clk_sel_e;

   // ==========================================================
   // counter-sized word
   typedef logic [15:0] tcp_word_t;

endpackage : tcp_pkg

// File: core/tcp_edge_det.sv
// edge detector for one pin with a selectable active edge
// assumes the pin is already synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module tcp_edge_det
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // pin and edge choice, 1 = rising
   input wire logic pin,
   input wire logic rising_sel,
   // one-cycle event
   output logic evt
);

   logic pin_reg;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         pin_reg <= 1'b0;
      else
         pin_reg <= pin;
   end

   assign evt = rising_sel ? (pin & ~pin_reg) : (~pin & pin_reg);

endmodule : tcp_edge_det
`default_nettype wire

// File: core/tcp_tick_gen.sv
// timer tick: clk divided by 2, 4 or 8, or an external edge event
// assumes the external event is at most one cycle long
`timescale 1ns/1ps
`default_nettype none
`include "tcp_map.svh"
module tcp_tick_gen
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // source select and external event
   input wire tcp_pkg::tcp_clk_sel_e clk_sel,
   input wire logic ext_evt,
   // one-cycle count strobe
   output logic tick
);

   logic [2:0] div_reg;
   logic [2:0] div_next;
   logic [2:0] div_last;
   logic wrap;

   assign div_last = (clk_sel == tcp_pkg::TCP_CLK_DIV2) ? `TCP_DIV2_LAST :
                     (clk_sel == tcp_pkg::TCP_CLK_DIV4) ? `TCP_DIV4_LAST :
                     `TCP_DIV8_LAST;
   assign wrap = (div_reg >= div_last);
   assign div_next = wrap ? 3'h0 : div_reg + 3'h1;
   assign tick = (clk_sel == tcp_pkg::TCP_CLK_EXT) ? ext_evt : wrap;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
         div_reg <= 3'h0;
      else
         div_reg <= div_next;
   end

endmodule : tcp_tick_gen
`default_nettype wire

// File: test/tcp_timer_compare_sva.sv
// port assertions for the compare/pulse/pwm timer
// assumes the map of tcp_map.svh; bound into tcp_timer_compare
`timescale 1ns/1ps
`default_nettype none
`include "tcp_map.svh"
module tcp_timer_compare_sva
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   // pins
   input wire logic compare_output_pin_1,
   input wire logic compare_output_pin_1_oe,
   input wire logic compare_output_pin_2,
   input wire logic compare_output_pin_2_oe,
   input wire logic cpu_irq_mask,
   input wire logic timer_irq
);
   // ==========
   // software shadows; only bus writes may change them
   logic [7:0] c1_reg;
   logic [7:0] c2_reg;
   logic [15:0] k1_reg;
   logic [15:0] k2_reg;
   wire wr_hit = psel && penable && pwrite;
   wire rd_hit = psel && penable && !pwrite;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         c1_reg <= 8'h00;
         c2_reg <= 8'h00;
         k1_reg <= 16'h8000;
         k2_reg <= 16'h8000;
      end
      else if (wr_hit)
      begin
         case (paddr)
            `TCP_OFF_CTRL1: c1_reg <= pwdata[7:0];
            `TCP_OFF_CTRL2: c2_reg <= pwdata[7:0];
            `TCP_OFF_CMP1_HI: k1_reg[15:8] <= pwdata[7:0];
            `TCP_OFF_CMP2_LO: k2_reg[7:0] <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // ==========
   // assertions
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);

   pins_reset_a:
      assert property (disable iff (1'b0) !rst_b |=> !compare_output_pin_1 && !compare_output_pin_2)
      else $error("compare pin high after reset");
   irq_mask_a:
      assert property (cpu_irq_mask |-> !timer_irq)
      else $error("interrupt while masked");
   irq_enables_a:
      assert property (c1_reg[7:5] == 3'h0 |-> !timer_irq)
      else $error("interrupt with all enables off");
   pin1_enable_a:
      assert property (wr_hit && paddr == `TCP_OFF_CTRL2 |=> compare_output_pin_1_oe == $past(pwdata[7]))
      else $error("pin 1 enable not following control");
   pin2_enable_a:
      assert property (wr_hit && paddr == `TCP_OFF_CTRL2
         |=> compare_output_pin_2_oe == ($past(pwdata[6]) && !$past(pwdata[5]) && !$past(pwdata[4])))
      else $error("pin 2 enable wrong for mode");
   cmp1_high_a:
      assert property (rd_hit && paddr == `TCP_OFF_CMP1_HI |-> prdata[7:0] == k1_reg[15:8])
      else $error("compare 1 high byte changed");
   cmp2_low_a:
      assert property (rd_hit && paddr == `TCP_OFF_CMP2_LO |-> prdata[7:0] == k2_reg[7:0])
      else $error("compare 2 low byte changed");
   force_level_a:
      assert property ($stable({c1_reg, c2_reg}) && c1_reg[3] && c2_reg[7] && !c2_reg[5] && !c2_reg[4]
         |-> compare_output_pin_1 == c1_reg[0])
      else $error("forced level not on pin 1");
endmodule : tcp_timer_compare_sva

bind tcp_timer_compare tcp_timer_compare_sva sva_i
(
   .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .compare_output_pin_1,
   .compare_output_pin_1_oe, .compare_output_pin_2, .compare_output_pin_2_oe, .cpu_irq_mask, .timer_irq
);
`default_nettype wire

// File: test/tcp_pin_partner.sv
// outside circuitry on the capture, clock and compare pins
// assumes the timer samples its pins on the rising clk edge
`timescale 1ns/1ps
`default_nettype none
module tcp_pin_partner
(
   // clock
   input wire logic clk,
   // pins toward the timer
   output var logic cap_pin_1,
   output var logic cap_pin_2,
   output logic ext_clk_pin,
   // compare pin and its last high time
   input wire logic cmp_pin_1,
   output var logic [15:0] high_len,
   output var logic [7:0] fall_cnt
);
   logic [15:0] run = 16'h0000;

   // external clock unused, held still
   assign ext_clk_pin = 1'b0;
   initial {cap_pin_1, cap_pin_2, high_len, fall_cnt} = 26'h0000000;

   // measure high time of compare pin 1 in clk cycles
   always @(posedge clk)
   begin
      if (cmp_pin_1)
         run <= run + 16'h0001;
      else if (run != 16'h0000)
      begin
         high_len <= run;
         fall_cnt <= fall_cnt + 8'h01;
         run <= 16'h0000;
      end
   end

   // rising pulse of four cycles on one capture pin
   task automatic pulse(input int which);
      @(posedge clk);
      if (which == 1)
         cap_pin_1 <= 1'b1;
      else
         cap_pin_2 <= 1'b1;
      repeat (4) @(posedge clk);
      cap_pin_1 <= 1'b0;
      cap_pin_2 <= 1'b0;
   endtask : pulse
endmodule : tcp_pin_partner
`default_nettype wire

// File: test/tcp_timer_compare_bench.sv
// self-checking bench for the compare/pulse/pwm timer
// assumes the core/ design files and the pin partner model
`timescale 1ns/1ps
`default_nettype none
`include "tcp_map.svh"
module tcp_timer_compare_bench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic cpu_irq_mask = 1'b1;
   wire [31:0] prdata;
   wire pready, pslverr, cap1, cap2, ext_clk, pin1, pin1_oe, pin2, pin2_oe, timer_irq;
   wire [15:0] high_len;
   wire [7:0] fall_cnt;
   logic [7:0] rd_q;
   logic err_q;
   logic [15:0] aim_v;
   int err_total = 0;
   int checked = 0;

   tcp_timer_compare dut
   (
      .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .trigger_capture_pin_1(cap1), .trigger_capture_pin_2(cap2), .ext_clock_pin(ext_clk),
      .compare_output_pin_1(pin1), .compare_output_pin_1_oe(pin1_oe), .compare_output_pin_2(pin2),
      .compare_output_pin_2_oe(pin2_oe), .cpu_irq_mask, .timer_irq
   );
   tcp_pin_partner partner
   (
      .clk, .cap_pin_1(cap1), .cap_pin_2(cap2), .ext_clk_pin(ext_clk), .cmp_pin_1(pin1), .high_len, .fall_cnt
   );

   initial
   begin
      forever #2.5 clk = ~clk;
   end

   // ==========
   // helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   // one apb transfer; entered and left just after a rising edge
   task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd_q = prdata[7:0];
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : bus

   task automatic rdc(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(16'(rd_q & m), 16'(e));
   endtask : rdc

   // point a compare channel d ticks ahead: high, status, low
   task automatic aim(input logic [11:0] hi, input logic [15:0] d);
      logic [7:0] h;
      bus(1'b0, `TCP_OFF_CNT_HI, 8'h00);
      h = rd_q;
      bus(1'b0, `TCP_OFF_CNT_LO, 8'h00);
      aim_v = {h, rd_q};
      bus(1'b0, `TCP_OFF_CNT_HI, 8'h00);
      if (rd_q !== h)
         aim_v = {rd_q, 8'h00};
      aim_v = aim_v + d;
      bus(1'b1, hi, aim_v[15:8]);
      bus(1'b0, `TCP_OFF_STATUS, 8'h00);
      bus(1'b1, hi + 12'h004, aim_v[7:0]);
   endtask : aim

   task automatic wait_pin(input logic lvl);
      int n;
      n = 0;
      while (pin1 !== lvl && n < 400)
      begin
         @(posedge clk);
         n++;
      end
      chk(16'(pin1), 16'(lvl));
   endtask : wait_pin

   // high time of pin 1 after c more falls, within lo..hi cycles
   task automatic meas(input logic [7:0] c, input logic [15:0] lo, input logic [15:0] hi);
      int n;
      logic [7:0] f;
      f = fall_cnt;
      n = 0;
      while (fall_cnt !== f + c && n < 9000)
      begin
         @(posedge clk);
         n++;
      end
      chk(16'(high_len >= lo && high_len <= hi), 16'h1);
   endtask : meas

   task automatic wrap_up();
      $display("comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : wrap_up

   // ==========
   // tests
   initial
   begin
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      rdc(`TCP_OFF_CMP1_HI, 8'hFF, 8'h80);
      rdc(`TCP_OFF_CMP2_LO, 8'hFF, 8'h00);
      rdc(12'h034, 8'hFF, 8'h00);
      chk(16'(err_q), 16'h1);
      $display("test reset values done");
      bus(1'b1, `TCP_OFF_CTRL2, 8'h80);
      bus(1'b1, `TCP_OFF_CTRL1, 8'h41);
      cpu_irq_mask <= 1'b0;
      aim(`TCP_OFF_CMP1_HI, 16'h0020);
      wait_pin(1'b1);
      chk(16'(timer_irq), 16'h1);
      cpu_irq_mask <= 1'b1;
      @(posedge clk);
      chk(16'(timer_irq), 16'h0);
      cpu_irq_mask <= 1'b0;
      rdc(`TCP_OFF_STATUS, 8'h40, 8'h40);
      rdc(`TCP_OFF_CMP1_LO, 8'h00, 8'h00);
      rdc(`TCP_OFF_STATUS, 8'h40, 8'h00);
      $display("test compare match done");
      // a lone high write must hold the channel off
      bus(1'b1, `TCP_OFF_CTRL1, 8'h40);
      aim(`TCP_OFF_CMP1_HI, 16'h0030);
      bus(1'b1, `TCP_OFF_CMP1_HI, aim_v[15:8]);
      repeat (150) @(posedge clk);
      chk(16'(pin1), 16'h1);
      rdc(`TCP_OFF_STATUS, 8'h40, 8'h00);
      aim(`TCP_OFF_CMP1_HI, 16'h0030);
      wait_pin(1'b0);
      rdc(`TCP_OFF_STATUS, 8'h40, 8'h40);
      rdc(`TCP_OFF_CMP1_LO, 8'h00, 8'h00);
      $display("test inhibit done");
      bus(1'b1, `TCP_OFF_CTRL1, 8'h09);
      repeat (2) @(posedge clk);
      chk(16'(pin1), 16'h1);
      bus(1'b1, `TCP_OFF_CTRL1, 8'h08);
      repeat (2) @(posedge clk);
      chk(16'(pin1), 16'h0);
      rdc(`TCP_OFF_STATUS, 8'h40, 8'h00);
      bus(1'b1, `TCP_OFF_CTRL2, 8'h00);
      chk(16'(pin1_oe), 16'h0);
      $display("test force done");
      bus(1'b1, `TCP_OFF_CMP1_HI, 8'h00);
      bus(1'b1, `TCP_OFF_CMP1_LO, 8'h10);
      bus(1'b1, `TCP_OFF_CTRL1, 8'h06);
      bus(1'b1, `TCP_OFF_CTRL2, 8'hA0);
      partner.pulse(1);
      meas(8'h1, 16'd38, 16'd43);
      chk(16'(pin1), 16'h0);
      rdc(`TCP_OFF_CAP1_HI, 8'hFF, 8'hFF);
      rdc(`TCP_OFF_CAP1_LO, 8'hFF, 8'hFD);
      rdc(`TCP_OFF_STATUS, 8'hC0, 8'h80);
      rdc(`TCP_OFF_CAP1_LO, 8'h00, 8'h00);
      $display("test one pulse done");
      // force left on: pwm must ignore it
      bus(1'b1, `TCP_OFF_CMP2_HI, 8'h01);
      bus(1'b1, `TCP_OFF_CMP2_LO, 8'h00);
      bus(1'b1, `TCP_OFF_CMP1_LO, 8'hF0);
      bus(1'b1, `TCP_OFF_CTRL1, 8'h09);
      for (int k = 0; k < 3; k++)
      begin
         bus(1'b1, `TCP_OFF_CTRL2, 8'hB2 | 8'(k << 2));
         meas(8'h2, 16'(32 << k), 16'(32 << k));
      end
      bus(1'b1, `TCP_OFF_CMP1_LO, 8'hE0);
      meas(8'h2, 16'd256, 16'd256);
      rdc(`TCP_OFF_STATUS, 8'hC8, 8'h80);
      bus(1'b1, `TCP_OFF_CTRL1, 8'h89);
      chk(16'(timer_irq), 16'h1);
      bus(1'b1, `TCP_OFF_CTRL1, 8'h49);
      chk(16'(timer_irq), 16'h0);
      partner.pulse(2);
      rdc(`TCP_OFF_STATUS, 8'h10, 8'h10);
      $display("test pwm done");
      wrap_up();
   end

   initial
   begin
      repeat (60000) @(posedge clk);
      err_total++;
      wrap_up();
   end
endmodule : tcp_timer_compare_bench
`default_nettype wire
